// file: logic/dcc_channel.sv
// Control and status logic for DMA channel two, with its AXI4-Lite slave.
// Assumes the fabric reports each beat's completion and error in one-cycle pulses.
//
// Register access over AXI4-Lite was decided locally.
`include "dcc_map.svh"
module dcc_channel (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write channels
   input wire logic [11:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read channels
   input wire logic [11:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Trigger and pacing inputs
   input wire logic trigger_in,
   input wire logic null_trigger,
   input wire logic [58:0] peripheral_data_request,
   input wire logic [3:0] timer_request,
   input wire logic sniff_enabled,
   input wire logic sniff_sel_this,
   // Fabric side
   input wire dcc_pkg::dcc_beat_t beat,
   input wire logic [31:0] beat_data,
   output logic issue_req,
   output logic issue_preferred,
   output logic [31:0] read_address,
   output logic [31:0] write_address,
   output logic [31:0] swapped_data,
   output logic [1:0] xfer_size,
   output logic sniff_advance,
   // Completion events
   output logic chain_fire,
   output logic [3:0] chain_index,
   output logic irq_pulse
);
   // Control register and live state
   dcc_pkg::dcc_ctrl_t ctrl_reg;
   // Sticky faults, cleared by a written one
   logic rd_fault_reg;
   logic wr_fault_reg;
   // Set at start, cleared by the last beat
   logic busy_reg;
   logic [31:0] raddr_reg, waddr_reg, count_reg;
   logic [31:0] raddr_next, waddr_next;
   logic [31:0] rdata_reg;
   logic chain_fire_reg, irq_reg, sniff_reg;
   logic [31:0] swap_reg;
   // Write path holding latches, so AW and W may arrive in either order
   logic aw_held, w_held, bvalid_reg, rvalid_reg;
   logic [11:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;

   // Write handshake decode
   wire aw_take = awvalid && !aw_held && !bvalid_reg;
   wire w_take = wvalid && !w_held && !bvalid_reg;
   wire aw_now = aw_held || aw_take;
   wire w_now = w_held || w_take;
   wire wr_fire = aw_now && w_now && !bvalid_reg;
   wire [11:0] wr_addr = aw_held ? aw_addr_reg : awaddr;
   wire [31:0] wr_data = w_held ? w_data_reg : wdata;
   wire [3:0] wr_strb = w_held ? w_strb_reg : wstrb;
   wire wr_ctrl = wr_fire && (wr_addr == `DCC_OFF_CTRL);
   wire wr_raddr = wr_fire && (wr_addr == `DCC_OFF_RADDR);
   wire wr_waddr = wr_fire && (wr_addr == `DCC_OFF_WADDR);
   wire wr_count = wr_fire && (wr_addr == `DCC_OFF_COUNT);
   wire wr_hit = wr_ctrl || wr_raddr || wr_waddr || wr_count;
   assign awready = aw_take;
   assign wready = w_take;
   assign bvalid = bvalid_reg;
   assign arready = !rvalid_reg;
   assign rvalid = rvalid_reg;
   assign rdata = rdata_reg;

   // Strobed merge of write data with a current value
   function automatic logic [31:0] merge(input logic [31:0] cur, input logic [31:0] nw,
                                         input logic [3:0] st);
      logic [31:0] m;
      m = cur;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            m[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return m;
   endfunction : merge

   // Pacing selection: peripheral, timer or permanent request
   wire [5:0] psel = ctrl_reg.psel;
   // Range test first: codes past the last line never pick one
   wire peripheral_data_request_sel = (psel <= `DCC_PSEL_PERIPHERAL_DATA_REQUEST_MAX) && peripheral_data_request[psel]; // [R12]
   // Timer index is the distance from the first timer code
   wire [5:0] tmr_off = psel - `DCC_PSEL_TMR0;
   wire tmr_sel = (psel >= `DCC_PSEL_TMR0) && (psel < `DCC_PSEL_FREE)
                  && timer_request[tmr_off[1:0]]; // [R13]
   wire pacing_request = peripheral_data_request_sel || tmr_sel || (psel == `DCC_PSEL_FREE); // [R14]

   // Any fault halts issue until both flags are cleared
   wire fault_any = rd_fault_reg || wr_fault_reg; // [R01]
   wire bus_err = beat.rd_err || beat.wr_err;
   // Triggers are lost while busy, disabled or faulted
   wire start_seq = trigger_in && ctrl_reg.en && !busy_reg && !fault_any; // [R08]
   assign issue_req = busy_reg && ctrl_reg.en && !fault_any && pacing_request; // [R02] [R08]
   assign issue_preferred = issue_req && ctrl_reg.pref; // [R22]
   // Sequence ends on the clean write of its last transfer
   wire last_done = busy_reg && beat.wr_done && !beat.wr_err && (count_reg == 32'h1);

   // Step size and ring-wrapped address update
   wire [31:0] step = (ctrl_reg.size == dcc_pkg::DCC_WORD) ? 32'h4 :
                      (ctrl_reg.size == dcc_pkg::DCC_HALF) ? 32'h2 : 32'h1; // [R21]
   wire [31:0] ring_mask = (ctrl_reg.ring == 4'h0) ? 32'hFFFFFFFF
                         : ((32'h1 << ctrl_reg.ring) - 32'h1); // [R18]
   // Only the masked low bits take the sum, so a ring stays aligned
   function automatic logic [31:0] advance(input logic [31:0] a, input logic [31:0] st,
                                           input logic [31:0] mk);
      logic [31:0] s;
      s = a + st;
      return (a & ~mk) | (s & mk);
   endfunction : advance
   // Ring applies to one side only
   wire [31:0] rmask = ctrl_reg.rsel ? 32'hFFFFFFFF : ring_mask; // [R17]
   wire [31:0] wmask = ctrl_reg.rsel ? ring_mask : 32'hFFFFFFFF; // [R17]
   // Addresses stop on the faulting beat, so they never run past it
   assign raddr_next = (beat.rd_done && !beat.rd_err && ctrl_reg.sinc)
                       ? advance(raddr_reg, step, rmask) : raddr_reg; // [R20] [R04]
   assign waddr_next = (beat.wr_done && !beat.wr_err && ctrl_reg.dinc)
                       ? advance(waddr_reg, step, wmask) : waddr_reg; // [R19] [R06]

   // Byte order per transfer width
   wire [31:0] swap_val = !ctrl_reg.swap ? beat_data :
      (ctrl_reg.size == dcc_pkg::DCC_WORD) ? {beat_data[7:0], beat_data[15:8],
                                             beat_data[23:16], beat_data[31:24]} :
      (ctrl_reg.size == dcc_pkg::DCC_HALF) ? {beat_data[23:16], beat_data[31:24],
                                             beat_data[7:0], beat_data[15:8]} :
      beat_data; // [R10]

   // Status word seen on read
   wire [31:0] ctrl_view = {fault_any, rd_fault_reg, wr_fault_reg, 4'h0, busy_reg,
                            ctrl_reg.sniff, ctrl_reg.swap, ctrl_reg.quiet, ctrl_reg.psel,
                            ctrl_reg.chain, ctrl_reg.rsel, ctrl_reg.ring, ctrl_reg.dinc,
                            ctrl_reg.sinc, ctrl_reg.size, ctrl_reg.pref, ctrl_reg.en}; // [R01]
   // Unmapped reads return zero with an error response
   wire [31:0] rd_mux = (araddr == `DCC_OFF_CTRL) ? ctrl_view :
                        (araddr == `DCC_OFF_RADDR) ? raddr_reg :
                        (araddr == `DCC_OFF_WADDR) ? waddr_reg :
                        (araddr == `DCC_OFF_COUNT) ? count_reg : 32'h0;
   wire rd_hit = (araddr == `DCC_OFF_CTRL) || (araddr == `DCC_OFF_RADDR)
                 || (araddr == `DCC_OFF_WADDR) || (araddr == `DCC_OFF_COUNT);
   // Byte strobes let software rewrite one control byte alone
   wire [31:0] ctrl_merged = merge(ctrl_view, wr_data, wr_strb);

   // AXI write handshake state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         bvalid_reg <= 1'b0;
         aw_addr_reg <= 12'h000;
         w_data_reg <= 32'h0;
         w_strb_reg <= 4'h0;
         bresp <= `DCC_RSP_OKAY;
      end else begin
         // Latch whichever half arrives first
         if (aw_take && !wr_fire) begin
            aw_held <= 1'b1;
            aw_addr_reg <= awaddr;
         end
         if (w_take && !wr_fire) begin
            w_held <= 1'b1;
            w_data_reg <= wdata;
            w_strb_reg <= wstrb;
         end
         if (wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            bvalid_reg <= 1'b1;
            // Unmapped writes are answered but change nothing
            bresp <= wr_hit ? `DCC_RSP_OKAY : `DCC_RSP_SLVERR;
         end else if (bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   // AXI read answer, one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0;
         rresp <= `DCC_RSP_OKAY;
      end else if (arvalid && !rvalid_reg) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_mux;
         rresp <= rd_hit ? `DCC_RSP_OKAY : `DCC_RSP_SLVERR;
      end else if (rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // Control fields; chain target comes out of reset at our own index
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= '0;
         ctrl_reg.chain <= `DCC_OWN_INDEX; // [R16]
      end else if (wr_ctrl) begin
         // Status bits above the fields are not stored
         ctrl_reg <= dcc_pkg::dcc_ctrl_t'(ctrl_merged[`DCC_BIT_SNIFF:0]);
      end
   end

   // Sticky faults: a new error wins over a same-cycle clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_fault_reg <= 1'b0;
         wr_fault_reg <= 1'b0;
      end else begin
         if (beat.rd_err) begin
            rd_fault_reg <= 1'b1; // [R03]
         end else if (wr_ctrl && wr_strb[3] && wr_data[`DCC_BIT_RDERR]) begin
            rd_fault_reg <= 1'b0; // [R23]
         end
         if (beat.wr_err) begin
            wr_fault_reg <= 1'b1; // [R05]
         end else if (wr_ctrl && wr_strb[3] && wr_data[`DCC_BIT_WRERR]) begin
            wr_fault_reg <= 1'b0; // [R23]
         end
      end
   end

   // Sequence state, addresses and remaining count
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         busy_reg <= 1'b0;
         raddr_reg <= 32'h0;
         waddr_reg <= 32'h0;
         count_reg <= 32'h0;
      end else begin
         raddr_reg <= wr_raddr ? wr_data : raddr_next;
         waddr_reg <= wr_waddr ? wr_data : waddr_next;
         // A faulted write leaves the count, so that beat runs again
         if (wr_count) begin
            count_reg <= wr_data;
         end else if (busy_reg && beat.wr_done && !beat.wr_err) begin
            count_reg <= count_reg - 32'h1;
         end
         if (start_seq) begin
            busy_reg <= 1'b1; // [R07]
         end else if (last_done) begin
            busy_reg <= 1'b0; // [R07]
         end
      end
   end

   // Completion events and data path outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chain_fire_reg <= 1'b0;
         irq_reg <= 1'b0;
         sniff_reg <= 1'b0;
         swap_reg <= 32'h0;
      end else begin
         chain_fire_reg <= last_done && (ctrl_reg.chain != `DCC_OWN_INDEX); // [R15]
         // Errors always interrupt; quiet mode keeps only the null trigger
         irq_reg <= bus_err || (ctrl_reg.quiet ? null_trigger : last_done); // [R02] [R11]
         // One checksum step per read beat
         sniff_reg <= beat.rd_done && ctrl_reg.sniff && sniff_enabled && sniff_sel_this; // [R09]
         swap_reg <= swap_val; // [R10]
      end
   end
   assign chain_fire = chain_fire_reg;
   assign chain_index = ctrl_reg.chain;
   assign irq_pulse = irq_reg;
   assign sniff_advance = sniff_reg;
   assign swapped_data = swap_reg;
   assign read_address = raddr_reg;
   assign write_address = waddr_reg;
   assign xfer_size = ctrl_reg.size;

   // Checks, all on aclk and masked during reset

   // Fault reporting
   a_err_irq_raised: assert property (@(posedge aclk) disable iff (!aresetn) // [R02]
      bus_err |=> irq_pulse) else $error("bus error gave no interrupt");
   a_err_flag_or: assert property (@(posedge aclk) disable iff (!aresetn) // [R01]
      ctrl_view[`DCC_BIT_BUSERR] == (rd_fault_reg || wr_fault_reg))
      else $error("error bit mismatch");
   a_rd_fault_set: assert property (@(posedge aclk) disable iff (!aresetn) // [R03]
      beat.rd_err |=> rd_fault_reg) else $error("read fault not set");
   a_wr_fault_set: assert property (@(posedge aclk) disable iff (!aresetn) // [R05]
      beat.wr_err |=> wr_fault_reg) else $error("write fault not set");
   a_fault_halts: assert property (@(posedge aclk) disable iff (!aresetn) // [R02]
      fault_any |-> !issue_req) else $error("issue during fault");

   // Enable and sequence framing
   a_pause_busy: assert property (@(posedge aclk) disable iff (!aresetn) // [R08]
      (busy_reg && !ctrl_reg.en) |=> busy_reg) else $error("busy dropped while paused");
   a_idle_ignores: assert property (@(posedge aclk) disable iff (!aresetn) // [R08]
      (trigger_in && !ctrl_reg.en && !busy_reg) |=> !busy_reg)
      else $error("disabled channel started");
   a_busy_starts: assert property (@(posedge aclk) disable iff (!aresetn) // [R07]
      start_seq |=> busy_reg) else $error("busy did not rise");
   a_busy_ends: assert property (@(posedge aclk) disable iff (!aresetn) // [R07]
      last_done |=> !busy_reg) else $error("busy did not fall");

   // Completion events
   a_chain_self: assert property (@(posedge aclk) disable iff (!aresetn) // [R15]
      chain_fire |-> $past(ctrl_reg.chain) != `DCC_OWN_INDEX) else $error("self chain");
   a_chain_fires: assert property (@(posedge aclk) disable iff (!aresetn) // [R15]
      (last_done && ctrl_reg.chain != `DCC_OWN_INDEX) |=> chain_fire)
      else $error("chain target not fired");
   a_quiet_calm: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
      (ctrl_reg.quiet && !bus_err && !null_trigger) |=> !irq_pulse)
      else $error("quiet channel interrupted");

   // A zero written over a set read fault must leave it set
   sequence s_zero_write;
      wr_ctrl && wr_strb[3] && !wr_data[`DCC_BIT_RDERR] && rd_fault_reg;
   endsequence
   a_zero_keeps: assert property (@(posedge aclk) disable iff (!aresetn) // [R23]
      s_zero_write |=> rd_fault_reg) else $error("zero write cleared fault");

   // Address movement
   a_raddr_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [R04]
      (beat.rd_err && !wr_raddr) |=> $stable(raddr_reg)) else $error("addr moved");
   a_waddr_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [R06]
      (beat.wr_err && !wr_waddr) |=> $stable(waddr_reg)) else $error("addr moved");
   a_src_fixed: assert property (@(posedge aclk) disable iff (!aresetn) // [R20]
      (!ctrl_reg.sinc && !wr_raddr) |=> $stable(raddr_reg)) else $error("source moved");
   a_dst_fixed: assert property (@(posedge aclk) disable iff (!aresetn) // [R19]
      (!ctrl_reg.dinc && !wr_waddr) |=> $stable(waddr_reg)) else $error("destination moved");
endmodule : dcc_channel

// file: logic/dcc_map.svh
// Register map, field positions and reset values for the channel two control block.
// Assumes a 32-bit AXI4-Lite slave port and one 25 MHz clock domain.
// What this block does
// R01: Bus-error bit is OR of fault flags
// R02: Any bus error halts and raises interrupt
// R03: Read error sets sticky source fault, W1C
// R04: Source address stays within three transfers of fault
// R05: Write error sets sticky destination fault, W1C
// R06: Destination address within five transfers of fault
// R07: Busy rises at start, falls at end
// R08: Enable gates triggers; clearing pauses, busy kept
// R09: Checksum visibility advances checksum when selected
// R10: Byte swap reverses halfwords and words
// R11: Quiet mode interrupts only on null trigger or bus error
// R12: Pacing values 0 to 0x3a pick peripheral requests
// R13: Values 0x3b to 0x3e pick pacing timers
// R14: Value 0x3f is permanent request
// R15: Completion triggers chain target unless own index
// R16: Chain target resets to two
// R17: Wrap-select picks source or destination ring
// R18: Ring size n keeps upper address bits
// R19: Destination increment advances write address
// R20: Source increment advances read address
// R21: Width field gives byte, halfword, word steps
// R22: Preferred flag feeds scheduler, not bus priority
// R23: Writing zero leaves fault flags; clear next cycle
`ifndef DCC_MAP_SVH
`define DCC_MAP_SVH
`define DCC_OFF_CTRL 12'h08C
`define DCC_OFF_RADDR 12'h090
`define DCC_OFF_WADDR 12'h094
`define DCC_OFF_COUNT 12'h098
`define DCC_BIT_BUSERR 31
`define DCC_BIT_RDERR 30
`define DCC_BIT_WRERR 29
`define DCC_BIT_BUSY 24
`define DCC_BIT_SNIFF 23
`define DCC_BIT_SWAP 22
`define DCC_BIT_QUIET 21
`define DCC_PSEL_HI 20
`define DCC_PSEL_LO 15
`define DCC_CHAIN_HI 14
`define DCC_CHAIN_LO 11
`define DCC_BIT_RSEL 10
`define DCC_RING_HI 9
`define DCC_RING_LO 6
`define DCC_BIT_DINC 5
`define DCC_BIT_SINC 4
`define DCC_SIZE_HI 3
`define DCC_SIZE_LO 2
`define DCC_BIT_PREF 1
`define DCC_BIT_EN 0
`define DCC_OWN_INDEX 4'h2
`define DCC_PSEL_PERIPHERAL_DATA_REQUEST_MAX 6'h3A
`define DCC_PSEL_TMR0 6'h3B
`define DCC_PSEL_FREE 6'h3F
`define DCC_NUM_PERIPHERAL_DATA_REQUEST 59
`define DCC_RSP_OKAY 2'h0
`define DCC_RSP_SLVERR 2'h2
`endif

// file: logic/dcc_pkg.sv
// Types for the channel two control block.
// Assumes dcc_map.svh supplies all numeric constants.
package dcc_pkg;
   // Transfer width encoding
   typedef enum logic [1:0] {DCC_BYTE = 2'h0, DCC_HALF = 2'h1, DCC_WORD = 2'h2} dcc_size_t;
   // Software-written control fields
   typedef struct packed {
      logic sniff;
      logic swap;
      logic quiet;
      logic [5:0] psel;
      logic [3:0] chain;
      logic rsel;
      logic [3:0] ring;
      logic dinc;
      logic sinc;
      logic [1:0] size;
      logic pref;
      logic en;
   } dcc_ctrl_t;
   // One bus beat report from the fabric side
   typedef struct packed {
      logic rd_done;
      logic rd_err;
      logic wr_done;
      logic wr_err;
   } dcc_beat_t;
endpackage : dcc_pkg

// file: dv/dcc_fabric_model.sv
// Bus fabric model: answers each issue request with one read beat, then one write beat unless the read beat faulted.
// Assumes issue_req is a settled level at each rising edge of aclk.
module dcc_fabric_model (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Channel side
   input wire logic issue_req,
   output dcc_pkg::dcc_beat_t beat,
   output logic [31:0] beat_data,
   // Scenario controls
   input wire logic slow,
   input wire logic inj_rd,
   input wire logic inj_wr
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] st_reg; // 0 idle, 1 wait, 2 cooldown, 3 write
   logic [1:0] dly_reg; // Wait states
   // Fixed pattern with four distinct bytes
   assign beat_data = 32'hA1B2C3D4;
   // Cooldown lets busy and fault flags land before the next look at issue_req
   always_ff @(posedge aclk) begin
      beat <= '0;
      if (!aresetn) begin
         st_reg <= 2'h0;
         dly_reg <= 2'h0;
      end else if (st_reg == 2'h0) begin
         st_reg <= issue_req ? 2'h1 : 2'h0;
         dly_reg <= slow ? 2'h3 : 2'h0;
      end else if (st_reg == 2'h1 && dly_reg != 2'h0) begin
         dly_reg <= dly_reg - 2'h1;
      end else if (st_reg == 2'h1) begin
         beat.rd_done <= !inj_rd;
         beat.rd_err <= inj_rd;
         st_reg <= inj_rd ? 2'h2 : 2'h3;
         dly_reg <= 2'h1;
      end else if (st_reg == 2'h3) begin
         beat.wr_done <= !inj_wr;
         beat.wr_err <= inj_wr;
         st_reg <= 2'h2;
      end else begin
         dly_reg <= dly_reg - 2'h1;
         st_reg <= (dly_reg == 2'h0) ? 2'h0 : 2'h2;
      end
   end
endmodule : dcc_fabric_model

// file: dv/tb.sv
// Self-checking bench for the channel two control block, driven over AXI4-Lite.
// Assumes the fabric model is the only source of bus beats.
`include "dcc_map.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
   $display("ERROR %s exp %h got %h", n, e, g); end end
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
   logic bvalid, arready, rvalid, trigger_in, null_trigger, sniff_enabled, sniff_sel_this;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd_val, beat_data, read_address, write_address, swapped_data;
   logic [3:0] wstrb, timer_request, chain_index;
   logic [1:0] bresp, rresp, rd_resp, xfer_size;
   logic [58:0] peripheral_data_request;
   dcc_pkg::dcc_beat_t beat;
   logic issue_req, issue_preferred, sniff_advance, chain_fire, irq_pulse, slow, inj_rd, inj_wr;
   int fails, total_checks, cycles, irq_n, chain_n, sniff_n, pref_n, irq0, ch0, s0;
   // Sequence table: control word, final addresses, swapped data, width
   logic [31:0] t_ctl [6] = '{32'h005FA831, 32'h005FA835, 32'h005FA839, 32'h005FA809,
      32'h005FA8F9, 32'h005FACF9};
   logic [31:0] t_ra [6] = '{32'h103, 32'h106, 32'h10C, 32'h100, 32'h104, 32'h10C};
   logic [31:0] t_wa [6] = '{32'h203, 32'h206, 32'h20C, 32'h200, 32'h20C, 32'h204};
   logic [31:0] t_sw [6] = '{32'hA1B2C3D4, 32'hB2A1D4C3, 32'hD4C3B2A1, 32'hD4C3B2A1,
      32'hD4C3B2A1, 32'hD4C3B2A1};
   logic [1:0] t_sz [6] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2};
   // Pacing table: control word and request line index
   logic [31:0] p_ctl [4] = '{32'h00029003, 32'h001D1001, 32'h001D9001, 32'h001F1001};
   int p_idx [4] = '{5, 58, 0, 3};
   dcc_channel dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .trigger_in, .null_trigger, .peripheral_data_request, .timer_request,
      .sniff_enabled, .sniff_sel_this, .beat, .beat_data, .issue_req, .issue_preferred,
      .read_address, .write_address, .swapped_data, .xfer_size, .sniff_advance, .chain_fire,
      .chain_index, .irq_pulse);
   dcc_fabric_model fab (.aclk(aclk), .aresetn(aresetn), .issue_req(issue_req), .beat(beat),
      .beat_data(beat_data), .slow(slow), .inj_rd(inj_rd), .inj_wr(inj_wr));
   // 25 MHz clock
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   // Event counters and hang guard
   always @(posedge aclk) begin
      cycles++;
      if (irq_pulse === 1'b1) irq_n++;
      if (chain_fire === 1'b1) chain_n++;
      if (sniff_advance === 1'b1) sniff_n++;
      if (issue_preferred === 1'b1) pref_n++;
      if (cycles == 30000) begin
         fails++;
         stop_test();
      end
   end
   // Ready is looked at on the falling edge, where it already shows what the next edge samples
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
      logic aw_t, w_t, b_t;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(negedge aclk);
         aw_t = awvalid & awready;
         w_t = wvalid & wready;
         b_t = bvalid;
         @(posedge aclk);
         if (aw_t) awvalid <= 1'b0;
         if (w_t) wvalid <= 1'b0;
         if (b_t) begin
            bready <= 1'b0;
            break;
         end
      end
   endtask : axi_wr
   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rs);
      logic ar_t, r_t;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(negedge aclk);
         ar_t = arvalid & arready;
         r_t = rvalid;
         d = rdata;
         rs = rresp;
         @(posedge aclk);
         if (ar_t) arvalid <= 1'b0;
         if (r_t) begin
            rready <= 1'b0;
            break;
         end
      end
   endtask : axi_rd
   // Program a sequence and trigger it
   task automatic start(input logic [31:0] ctl, input logic [31:0] cnt);
      axi_wr(`DCC_OFF_COUNT, cnt);
      axi_wr(`DCC_OFF_RADDR, 32'h100);
      axi_wr(`DCC_OFF_WADDR, 32'h200);
      axi_wr(`DCC_OFF_CTRL, ctl);
      @(posedge aclk);
      trigger_in <= 1'b1;
      @(posedge aclk);
      trigger_in <= 1'b0;
   endtask : start
   // Poll busy, bounded
   task automatic wait_idle();
      for (int i = 0; i < 100; i++) begin
         axi_rd(`DCC_OFF_CTRL, rd_val, rd_resp);
         if (rd_val[`DCC_BIT_BUSY] === 1'b0) return;
      end
      `CHK("idle", 1'b0, 1'b1)
   endtask : wait_idle
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : stop_test
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, trigger_in, null_trigger} = '0;
      {awaddr, araddr, wdata, wstrb, timer_request, peripheral_data_request} = '0;
      {sniff_enabled, sniff_sel_this, slow, inj_rd, inj_wr, aresetn} = '0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(`DCC_OFF_CTRL, rd_val, rd_resp);
      `CHK("ctl_rst", 32'h00001000, rd_val)
      `CHK("idx_rst", 4'h2, chain_index)
      `CHK("rresp", 2'h0, rd_resp)
      axi_rd(12'h0F0, rd_val, rd_resp);
      `CHK("unmap", {2'h2, 32'h0}, {rd_resp, rd_val})
      axi_wr(12'h0F0, 32'hFFFFFFFF);
      `CHK("wr_unmap", 2'h2, bresp)
      axi_wr(`DCC_OFF_CTRL, 32'h00FFFFFE);
      `CHK("wr_ok", 2'h0, bresp)
      axi_rd(`DCC_OFF_CTRL, rd_val, rd_resp);
      `CHK("ctl_rw", 32'h00FFFFFE, rd_val)
      // Width, increment, ring and swap under permanent request
      for (int r = 0; r < 6; r++) begin
         slow <= r[0];
         ch0 = chain_n;
         irq0 = irq_n;
         start(t_ctl[r], 32'h3);
         wait_idle();
         repeat (2) @(posedge aclk);
         `CHK("raddr", t_ra[r], read_address)
         `CHK("waddr", t_wa[r], write_address)
         `CHK("swap", t_sw[r], swapped_data)
         `CHK("size", t_sz[r], xfer_size)
         `CHK("chain", 4'h5, chain_index)
         `CHK("fires", ch0 + 1, chain_n)
         `CHK("irq_end", irq0 + 1, irq_n)
      end
      // Pacing sources, with the preferred bit on the first only
      for (int p = 0; p < 4; p++) begin
         s0 = pref_n;
         ch0 = chain_n;
         start(p_ctl[p], 32'h1);
         repeat (3) @(posedge aclk);
         `CHK("gated", 1'b0, issue_req)
         if (p < 2) peripheral_data_request <= 59'h1 << p_idx[p];
         else timer_request <= 4'h1 << p_idx[p];
         wait_idle();
         peripheral_data_request <= '0;
         timer_request <= '0;
         `CHK("pref", p == 0, pref_n > s0)
         repeat (2) @(posedge aclk);
         `CHK("no_chain", ch0, chain_n)
      end
      // Disabled channel ignores triggers; clearing enable pauses
      start(32'h00001000, 32'h2);
      axi_rd(`DCC_OFF_CTRL, rd_val, rd_resp);
      `CHK("no_start", 1'b0, rd_val[`DCC_BIT_BUSY])
      start(32'h0003B001, 32'h2);
      axi_wr(`DCC_OFF_CTRL, 32'h001F9000);
      repeat (3) @(posedge aclk);
      `CHK("paused", 1'b0, issue_req)
      axi_rd(`DCC_OFF_CTRL, rd_val, rd_resp);
      `CHK("busy_kept", 1'b1, rd_val[`DCC_BIT_BUSY])
      axi_wr(`DCC_OFF_CTRL, 32'h001F9001);
      wait_idle();
      // Checksum visibility, selected and not
      for (int j = 0; j < 2; j++) begin
         sniff_enabled <= 1'b1;
         sniff_sel_this <= (j == 0);
         s0 = sniff_n;
         start(32'h009F9001, 32'h2);
         wait_idle();
         `CHK("sniff", (j == 0) ? 2 : 0, sniff_n - s0)
      end
      // Read then write fault, in quiet mode
      for (int e = 0; e < 2; e++) begin
         inj_rd <= (e == 0);
         inj_wr <= (e == 1);
         irq0 = irq_n;
         start(32'h003F9039, 32'h3);
         for (int i = 0; i < 100 && irq_n == irq0; i++) @(posedge aclk);
         inj_rd <= 1'b0;
         inj_wr <= 1'b0;
         axi_rd(`DCC_OFF_CTRL, rd_val, rd_resp);
         `CHK("flags", (e == 0) ? 3'b110 : 3'b101, rd_val[31:29])
         `CHK("irq_err", irq0 + 1, irq_n)
         if (e == 0) `CHK("ra_win", 1'b1, read_address inside {[32'h100:32'h10C]})
         else `CHK("wa_win", 1'b1, write_address inside {[32'h200:32'h214]})
         axi_wr(`DCC_OFF_CTRL, 32'h003F9039);
         axi_rd(`DCC_OFF_CTRL, rd_val, rd_resp);
         `CHK("keep0", (e == 0) ? 3'b110 : 3'b101, rd_val[31:29])
         axi_wr(`DCC_OFF_CTRL, (e == 0) ? 32'h403F9039 : 32'h203F9039);
         axi_rd(`DCC_OFF_CTRL, rd_val, rd_resp);
         `CHK("clr", 3'b000, rd_val[31:29])
         wait_idle();
         `CHK("quiet", irq0 + 1, irq_n)
         @(posedge aclk);
         null_trigger <= 1'b1;
         @(posedge aclk);
         null_trigger <= 1'b0;
         repeat (3) @(posedge aclk);
         `CHK("null_irq", irq0 + 2, irq_n)
      end
      stop_test();
   end
endmodule : tb
